// File: pin_share_pkg.sv
// Constants shared by the host-port pin sharing block and its helpers.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package pin_share_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 16;
	localparam int BYTE_W   = 8;
	localparam int AXI_AW   = 8;
	localparam int AXI_DW   = 32;
	localparam int CTRL_W   = 4;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [AXI_AW-1:0] OFF_BANK_SWITCH_CONTROL_REG     = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_GPIO_DIR = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_GPIO_OUT = 8'h08;
	localparam logic [AXI_AW-1:0] OFF_GPIO_IN  = 8'h0C;
	localparam logic [AXI_AW-1:0] OFF_STATUS   = 8'h10;
	localparam logic [AXI_AW-1:0] OFF_ADDR_PIN = 8'h14;
	localparam logic [AXI_AW-1:0] OFF_DATA_PIN = 8'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BANK_SWITCH_CONTROL_REG_DATA_KEEP = 0;
	localparam int BANK_SWITCH_CONTROL_REG_HOST_KEEP = 1;
	localparam int ST_WORD_MODE   = 0;
	localparam int ST_PORT_EN     = 1;
	localparam int ST_HOLD        = 2;
	localparam int ST_OFF         = 3;
	localparam int ST_OWNER_LSB   = 4;
	localparam int ST_KEEP_LSB    = 6;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0]        RST_BANK_SWITCH_CONTROL_REG     = 2'h0;
	localparam logic [BYTE_W-1:0] RST_GPIO_DIR = 8'h00;
	localparam logic [BYTE_W-1:0] RST_GPIO_OUT = 8'h00;

	// ------------------------------------------------------------
	// Bus answers and bus owner
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OWN_NONE,
		OWN_CORE,
		OWN_HOST
	} owner_t;

endpackage

// File: pin_sync2.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to mclk_i; state freezes while ce_i is low.
`timescale 1ns/1ps
module pin_sync2 #(
	parameter int W = 1
) (
	// Clock and control
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	initial begin
		if (W < 1) $error("pin_sync2: W must be at least 1");
	end

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	// First stage feeds only the second stage
	always_comb begin
		s_d = s_q;
		s_d.meta = d_i;
		s_d.q = s_q.meta;
		if (rst_i) begin
			s_d.meta = d_i;
			s_d.q = s_q.meta;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.q;
endmodule

// File: bus_keeper.sv
// Bus holder control for one group of pins.
// Assumes drive_i/level_i are the registered pin drive of the owner module.
`timescale 1ns/1ps
module bus_keeper #(
	parameter int W = 8
) (
	// Clock and control
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// Keeper enable and pin drive
	input  wire logic         enable_i,
	input  wire logic [W-1:0] drive_i,
	input  wire logic [W-1:0] level_i,
	// Weak hold drive
	output logic      [W-1:0] hold_val_o,
	output logic      [W-1:0] hold_en_o
);
	initial begin
		if (W < 1) $error("bus_keeper: W must be at least 1");
	end

	typedef struct packed {
		logic [W-1:0] last;
	} keep_state_t;

	keep_state_t s_q;
	keep_state_t s_d;

	// Remember the level most recently driven on each pin
	always_comb begin
		s_d = s_q;
		for (int i = 0; i < W; i++) begin
			if (drive_i[i]) begin
				s_d.last[i] = level_i[i];
			end
		end
		if (rst_i) begin
			s_d = '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign hold_val_o = s_q.last;
	assign hold_en_o  = {W{enable_i}} & ~drive_i;
endmodule

// File: pin_share_top.sv
// Pin sharing and bus keeper control for the host-port address and data pins.
// Assumes core and host-port logic on mclk_i; pins synchronised here.
// Function
// - In word host mode the host addresses on-chip memory over the shared address pins.
// - In word host mode the host reads and writes on-chip memory over the sixteen data pins.
// - The address pins are shared among core memory, core I/O and the word-mode host port.
// - Address keepers are off after reset and then follow the host keeper enable bit.
// - Data keepers are off after reset and then follow the data keeper enable bit.
// - An enabled keeper holds each undriven pin at the level last driven onto it.
// - Data pins float when not driving, during chip reset and during a hold request.
// - Data pins float while the output-disable input is low.
// - Byte host pins act as general I/O when the host port is off or word mode is set.
// - Byte host pins float when not driving and while output-disable is low.
// - In byte mode the byte keepers are off after reset and then follow the host keeper enable bit.
// - In word mode the byte keepers are on at all times except during chip reset.
// - Word host mode select is captured at reset and must stay stable afterwards.
// - The host port is enabled only if its enable pin is high as reset ends.
`timescale 1ns/1ps
module pin_share_top
	import pin_share_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic                          mclk_i,
	input  wire logic                          rst_i,
	input  wire logic                          ce_i,
	// AXI4-Lite slave
	input  wire logic [pin_share_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [pin_share_pkg::AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [pin_share_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [pin_share_pkg::AXI_DW-1:0]   s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Control pins
	input  wire logic                          word_host_mode_sel_i,
	input  wire logic                          host_port_enable_pin_i,
	input  wire logic                          hold_req_i,
	input  wire logic                          out_disable_n_i,
	// Core external bus
	input  wire logic                          core_ext_req_i,
	input  wire logic                          core_wr_i,
	input  wire logic [pin_share_pkg::ADDR_W-1:0] core_addr_i,
	input  wire logic [pin_share_pkg::DATA_W-1:0] core_wdata_i,
	output logic      [pin_share_pkg::DATA_W-1:0] core_rdata_o,
	// Host port memory side
	input  wire logic                          host_rd_i,
	input  wire logic [pin_share_pkg::DATA_W-1:0] host_mem_rdata_i,
	output logic      [pin_share_pkg::ADDR_W-1:0] host_mem_addr_o,
	output logic      [pin_share_pkg::DATA_W-1:0] host_mem_wdata_o,
	output logic                               word_mode_o,
	output logic                               port_en_o,
	// Host port byte data (byte mode)
	input  wire logic [pin_share_pkg::BYTE_W-1:0] hbyte_out_i,
	input  wire logic                          hbyte_oe_i,
	output logic      [pin_share_pkg::BYTE_W-1:0] hbyte_in_o,
	// Address pins
	input  wire logic [pin_share_pkg::ADDR_W-1:0] ext_addr_pins_i,
	output logic      [pin_share_pkg::ADDR_W-1:0] ext_addr_pins_o,
	output logic      [pin_share_pkg::ADDR_W-1:0] ext_addr_pins_oe_o,
	output logic      [pin_share_pkg::ADDR_W-1:0] addr_hold_val_o,
	output logic      [pin_share_pkg::ADDR_W-1:0] addr_hold_en_o,
	// Data pins
	input  wire logic [pin_share_pkg::DATA_W-1:0] ext_data_pins_i,
	output logic      [pin_share_pkg::DATA_W-1:0] ext_data_pins_o,
	output logic      [pin_share_pkg::DATA_W-1:0] ext_data_pins_oe_o,
	output logic      [pin_share_pkg::DATA_W-1:0] data_hold_val_o,
	output logic      [pin_share_pkg::DATA_W-1:0] data_hold_en_o,
	// Byte host data pins
	input  wire logic [pin_share_pkg::BYTE_W-1:0] host_byte_data_pins_i,
	output logic      [pin_share_pkg::BYTE_W-1:0] host_byte_data_pins_o,
	output logic      [pin_share_pkg::BYTE_W-1:0] host_byte_data_pins_oe_o,
	output logic      [pin_share_pkg::BYTE_W-1:0] byte_hold_val_o,
	output logic      [pin_share_pkg::BYTE_W-1:0] byte_hold_en_o
);
	import pin_share_pkg::*;

	localparam int SYNC_W = ADDR_W + DATA_W + BYTE_W + CTRL_W;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic              word_mode;
		logic              port_en;
		logic [1:0]        bank_switch_control_reg;
		logic [BYTE_W-1:0] gpio_dir;
		logic [BYTE_W-1:0] gpio_out;
		logic              addr_keep_en;
		logic              data_keep_en;
		logic              byte_keep_en;
		logic [ADDR_W-1:0] addr_out;
		logic              addr_oe;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
		logic [BYTE_W-1:0] byte_out;
		logic [BYTE_W-1:0] byte_oe;
		logic [ADDR_W-1:0] host_addr;
		logic [DATA_W-1:0] host_wdata;
		logic [DATA_W-1:0] core_rdata;
		logic [BYTE_W-1:0] byte_in;
		owner_t            owner;
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [AXI_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0]        rresp;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] sync_q;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic [BYTE_W-1:0] byte_s;
	logic              word_sel_s;
	logic              port_pin_s;
	logic              hold_s;
	logic              off_n_s;

	pin_sync2 #(.W(SYNC_W)) u_sync (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.d_i    ({ext_addr_pins_i, ext_data_pins_i, host_byte_data_pins_i,
			word_host_mode_sel_i, host_port_enable_pin_i, hold_req_i, out_disable_n_i}),
		.q_o    (sync_q)
	);

	assign {addr_s, data_s, byte_s, word_sel_s, port_pin_s, hold_s, off_n_s} = sync_q;

	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------
	function automatic logic [AXI_DW+1:0] read_reg(input logic [AXI_AW-1:0] a,
		input top_state_t s, input logic hold, input logic off_n);
		logic [AXI_DW-1:0] d;
		logic [1:0]        r;
		d = '0;
		r = RESP_OKAY;
		case ({a[AXI_AW-1:2], 2'b00})
			OFF_BANK_SWITCH_CONTROL_REG:     d[1:0] = s.bank_switch_control_reg;
			OFF_GPIO_DIR: d[BYTE_W-1:0] = s.gpio_dir;
			OFF_GPIO_OUT: d[BYTE_W-1:0] = s.gpio_out;
			OFF_GPIO_IN:  d[BYTE_W-1:0] = s.byte_in;
			OFF_STATUS: begin
				d[ST_WORD_MODE] = s.word_mode;
				d[ST_PORT_EN] = s.port_en;
				d[ST_HOLD] = hold;
				d[ST_OFF] = ~off_n;
				d[ST_OWNER_LSB +: 2] = s.owner;
				d[ST_KEEP_LSB +: 3] = {s.byte_keep_en, s.data_keep_en, s.addr_keep_en};
			end
			OFF_ADDR_PIN: d[ADDR_W-1:0] = s.host_addr;
			OFF_DATA_PIN: d[DATA_W-1:0] = s.core_rdata;
			default:      r = RESP_SLVERR;
		endcase
		return {r, d};
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic              gpio_ok;
	logic              can_drive;
	logic              do_write;
	logic [AXI_DW+1:0] rd;

	always_comb begin
		s_d = s_q;
		rd = '0;

		// Bus owner: hold releases the address and data pins, reset releases every pin
		if (hold_s) begin
			s_d.owner = OWN_NONE;
		end else if (core_ext_req_i) begin
			s_d.owner = OWN_CORE;
		end else if (s_q.word_mode && s_q.port_en) begin
			s_d.owner = OWN_HOST;
		end else begin
			s_d.owner = OWN_NONE;
		end

		// Address pins: driven by the core, sampled for the host
		s_d.addr_oe = (s_d.owner == OWN_CORE);
		s_d.addr_out = core_addr_i;
		if (s_d.owner == OWN_HOST) begin
			s_d.host_addr = addr_s;
			s_d.host_wdata = data_s;
		end

		// Data pins: core write or host read data, else floated
		can_drive = off_n_s && !hold_s;
		s_d.data_oe = can_drive && ((s_d.owner == OWN_CORE && core_wr_i) ||
			(s_d.owner == OWN_HOST && host_rd_i));
		s_d.data_out = (s_d.owner == OWN_HOST) ? host_mem_rdata_i : core_wdata_i;
		if (s_d.owner == OWN_CORE) begin
			s_d.core_rdata = data_s;
		end

		// Byte host pins: general I/O or byte host port
		gpio_ok = !s_q.port_en || s_q.word_mode;
		if (gpio_ok) begin
			s_d.byte_oe = s_q.gpio_dir & {BYTE_W{off_n_s}};
			s_d.byte_out = s_q.gpio_out;
		end else begin
			s_d.byte_oe = {BYTE_W{hbyte_oe_i && off_n_s}};
			s_d.byte_out = hbyte_out_i;
		end
		s_d.byte_in = byte_s;

		// Keeper enables
		s_d.addr_keep_en = s_q.bank_switch_control_reg[BANK_SWITCH_CONTROL_REG_HOST_KEEP];
		s_d.data_keep_en = s_q.bank_switch_control_reg[BANK_SWITCH_CONTROL_REG_DATA_KEEP];
		s_d.byte_keep_en = s_q.word_mode || s_q.bank_switch_control_reg[BANK_SWITCH_CONTROL_REG_HOST_KEEP];

		// AXI4-Lite write channel
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
		if (do_write) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			// All writable fields sit in byte lane 0
			case ({s_q.awaddr[AXI_AW-1:2], 2'b00})
				OFF_BANK_SWITCH_CONTROL_REG: begin
					if (s_q.wstrb[0]) s_d.bank_switch_control_reg = s_q.wdata[1:0];
				end
				OFF_GPIO_DIR: begin
					if (s_q.wstrb[0]) s_d.gpio_dir = s_q.wdata[BYTE_W-1:0];
				end
				OFF_GPIO_OUT: begin
					if (s_q.wstrb[0]) s_d.gpio_out = s_q.wdata[BYTE_W-1:0];
				end
				OFF_GPIO_IN, OFF_STATUS, OFF_ADDR_PIN, OFF_DATA_PIN: begin
					s_d.bresp = RESP_OKAY;
				end
				default: s_d.bresp = RESP_SLVERR;
			endcase
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// AXI4-Lite read channel
		if (s_axi_arvalid && s_axi_arready) begin
			rd = read_reg(s_axi_araddr, s_q, hold_s, off_n_s);
			s_d.rvalid = 1'b1;
			s_d.rresp = rd[AXI_DW+1:AXI_DW];
			s_d.rdata = rd[AXI_DW-1:0];
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Chip reset: everything floated, keepers off, straps follow the pins
		if (rst_i) begin
			s_d = '0;
			s_d.bank_switch_control_reg = RST_BANK_SWITCH_CONTROL_REG;
			s_d.gpio_dir = RST_GPIO_DIR;
			s_d.gpio_out = RST_GPIO_OUT;
			s_d.word_mode = word_sel_s;
			s_d.port_en = port_pin_s;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Keepers
	// ------------------------------------------------------------
	bus_keeper #(.W(ADDR_W)) u_addr_keep (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.enable_i   (s_q.addr_keep_en),
		.drive_i    ({ADDR_W{s_q.addr_oe}}),
		.level_i    (s_q.addr_out),
		.hold_val_o (addr_hold_val_o),
		.hold_en_o  (addr_hold_en_o)
	);

	bus_keeper #(.W(DATA_W)) u_data_keep (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.enable_i   (s_q.data_keep_en),
		.drive_i    ({DATA_W{s_q.data_oe}}),
		.level_i    (s_q.data_out),
		.hold_val_o (data_hold_val_o),
		.hold_en_o  (data_hold_en_o)
	);

	bus_keeper #(.W(BYTE_W)) u_byte_keep (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.enable_i   (s_q.byte_keep_en),
		.drive_i    (s_q.byte_oe),
		.level_i    (s_q.byte_out),
		.hold_val_o (byte_hold_val_o),
		.hold_en_o  (byte_hold_en_o)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Handshake readies are combinational; a new write waits for the old answer
	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	assign ext_addr_pins_o          = s_q.addr_out;
	assign ext_addr_pins_oe_o       = {ADDR_W{s_q.addr_oe}};
	assign ext_data_pins_o          = s_q.data_out;
	assign ext_data_pins_oe_o       = {DATA_W{s_q.data_oe}};
	assign host_byte_data_pins_o    = s_q.byte_out;
	assign host_byte_data_pins_oe_o = s_q.byte_oe;

	assign core_rdata_o     = s_q.core_rdata;
	assign host_mem_addr_o  = s_q.host_addr;
	assign host_mem_wdata_o = s_q.host_wdata;
	assign hbyte_in_o       = s_q.byte_in;
	assign word_mode_o      = s_q.word_mode;
	assign port_en_o        = s_q.port_en;
endmodule

// File: pin_share_monitor.sv
// Checker on the ports of pin_share_top.
// Assumes ce_i stays high while it watches.
`timescale 1ns/1ps
module pin_share_monitor (
	// Clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_i,
	// Control and owners
	input wire logic        hold_req_i,
	input wire logic        out_disable_n_i,
	input wire logic        core_ext_req_i,
	input wire logic        core_wr_i,
	input wire logic [15:0] core_addr_i,
	input wire logic [15:0] core_wdata_i,
	input wire logic        host_rd_i,
	input wire logic [15:0] host_mem_rdata_i,
	input wire logic [15:0] host_mem_addr_o,
	input wire logic        word_mode_o,
	input wire logic        port_en_o,
	// Pins
	input wire logic [15:0] ext_addr_pins_i,
	input wire logic [15:0] ext_addr_pins_o,
	input wire logic [15:0] ext_addr_pins_oe_o,
	input wire logic [15:0] addr_hold_en_o,
	input wire logic [15:0] ext_data_pins_o,
	input wire logic [15:0] ext_data_pins_oe_o,
	input wire logic [15:0] data_hold_val_o,
	input wire logic [15:0] data_hold_en_o,
	input wire logic [7:0]  host_byte_data_pins_oe_o,
	input wire logic [7:0]  byte_hold_en_o
);
	// Raw hold is used; five-cycle windows cover the pin synchroniser
	wire host_owns = word_mode_o && port_en_o && !core_ext_req_i && !hold_req_i;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_quiet;
		(!hold_req_i && out_disable_n_i)[*5];
	endsequence
	sequence s_release;
		ext_data_pins_oe_o[0] ##1 !ext_data_pins_oe_o[0];
	endsequence
	chk_reset_quiet: assert property ($past(rst_i) |->
		ext_data_pins_oe_o == '0 && addr_hold_en_o == '0 && data_hold_en_o == '0)
		else $error("pins or keepers active after reset");
	chk_hold_float: assert property (hold_req_i[*5] |->
		ext_data_pins_oe_o == '0 && ext_addr_pins_oe_o == '0) else $error("drive in hold");
	chk_off_float: assert property ((!out_disable_n_i)[*5] |->
		ext_data_pins_oe_o == '0 && host_byte_data_pins_oe_o == '0) else $error("drive while off");
	chk_keep_last: assert property (s_release |->
		data_hold_val_o == $past(ext_data_pins_o)) else $error("keeper level wrong");
	chk_word_keep: assert property (word_mode_o[*3] |->
		byte_hold_en_o == ~host_byte_data_pins_oe_o) else $error("byte keepers off");
	chk_core_drive: assert property (s_quiet ##0 (core_ext_req_i && core_wr_i) |=>
		ext_data_pins_oe_o == '1 && ext_data_pins_o == $past(core_wdata_i)
		&& ext_addr_pins_oe_o == '1 && ext_addr_pins_o == $past(core_addr_i))
		else $error("core write not driven");
	chk_core_read: assert property (s_quiet ##0 (core_ext_req_i && !core_wr_i) |=>
		ext_addr_pins_oe_o == '1 && ext_data_pins_oe_o == '0) else $error("core read drive");
	chk_host_addr: assert property ((host_owns && $stable(ext_addr_pins_i))[*5] |->
		ext_addr_pins_oe_o == '0 && host_mem_addr_o == ext_addr_pins_i)
		else $error("host address lost");
	chk_host_read: assert property ((host_owns && out_disable_n_i)[*5] ##0 host_rd_i |=>
		ext_data_pins_oe_o == '1 && ext_data_pins_o == $past(host_mem_rdata_i))
		else $error("host read not driven");
endmodule
bind pin_share_top pin_share_monitor u_monitor (.*);

// File: far_side_model.sv
// Far-side party on one group of shared pins: external host or memory.
// Assumes the device drive wins; it only drives what the device released.
`timescale 1ns/1ps
module far_side_model #(
	parameter int W = 16
) (
	input  wire logic         mclk_i,
	input  wire logic         drive_req_i,
	input  wire logic [W-1:0] drive_val_i,
	input  wire logic [W-1:0] dev_oe_i,
	input  wire logic [W-1:0] dev_val_i,
	input  wire logic [W-1:0] hold_en_i,
	input  wire logic [W-1:0] hold_val_i,
	output logic      [W-1:0] pins_o
);
	// Floating bits toggle so no stale level passes for a held one
	logic [W-1:0] noise_q = '0;
	always @(posedge mclk_i) noise_q <= ~noise_q;
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (dev_oe_i[i])
				pins_o[i] = dev_val_i[i];
			else if (drive_req_i)
				pins_o[i] = drive_val_i[i];
			else if (hold_en_i[i])
				pins_o[i] = hold_val_i[i];
			else
				pins_o[i] = noise_q[i];
		end
	end
endmodule

// File: host_port_pin_sharing_tb_top.sv
// Bench for pin_share_top: random pin traffic, registers, keepers.
// Assumes the monitor and far_side_model are compiled before it.
`timescale 1ns/1ps
module host_port_pin_sharing_tb_top;
	import pin_share_pkg::*;
	// ---------
	// Signals
	// ---------
	logic        mclk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        word_host_mode_sel_i = 1'h0, host_port_enable_pin_i = 1'h0, fs_drv = 1'h0;
	logic        hold_req_i = 1'h0, out_disable_n_i = 1'h1, core_ext_req_i = 1'h0;
	logic        core_wr_i = 1'h0, host_rd_i = 1'h0, hbyte_oe_i = 1'h0, word_mode_o, port_en_o;
	logic [15:0] core_addr_i = '0, core_wdata_i = '0, host_mem_rdata_i = '0, fs_val = '0;
	logic [15:0] core_rdata_o, host_mem_addr_o, host_mem_wdata_o;
	logic [7:0]  hbyte_out_i = '0, hbyte_in_o, byte_hold_val_o, byte_hold_en_o;
	logic [15:0] ext_addr_pins_i, ext_addr_pins_o, ext_addr_pins_oe_o, addr_hold_val_o;
	logic [15:0] ext_data_pins_i, ext_data_pins_o, ext_data_pins_oe_o, data_hold_val_o;
	logic [15:0] addr_hold_en_o, data_hold_en_o;
	logic [7:0]  host_byte_data_pins_i, host_byte_data_pins_o, host_byte_data_pins_oe_o;
	int          failures = 0, samples_checked = 0, cycles = 0;
	// ---------
	// Design and far side
	// ---------
	pin_share_top uut (.*);
	far_side_model #(.W(16)) addr_side (.mclk_i, .drive_req_i(fs_drv), .drive_val_i(fs_val),
		.dev_oe_i(ext_addr_pins_oe_o), .dev_val_i(ext_addr_pins_o), .hold_en_i(addr_hold_en_o),
		.hold_val_i(addr_hold_val_o), .pins_o(ext_addr_pins_i));
	far_side_model #(.W(16)) data_side (.mclk_i, .drive_req_i(fs_drv), .drive_val_i(~fs_val),
		.dev_oe_i(ext_data_pins_oe_o), .dev_val_i(ext_data_pins_o), .hold_en_i(data_hold_en_o),
		.hold_val_i(data_hold_val_o), .pins_o(ext_data_pins_i));
	far_side_model #(.W(8)) byte_side (.mclk_i, .drive_req_i(fs_drv), .drive_val_i(fs_val[7:0]),
		.dev_oe_i(host_byte_data_pins_oe_o), .dev_val_i(host_byte_data_pins_o),
		.hold_en_i(byte_hold_en_o), .hold_val_i(byte_hold_val_o), .pins_o(host_byte_data_pins_i));
	always #10 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			print_verdict();
		end
	end
	// ---------
	// Tasks
	// ---------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] byte_keep_exp(input logic w, input logic hk);
		return w ? 8'hFF : {8{hk}};
	endfunction
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin do @(posedge mclk_i); while (s_axi_awready !== 1'h1); s_axi_awvalid <= 1'h0; end
			begin do @(posedge mclk_i); while (s_axi_wready !== 1'h1); s_axi_wvalid <= 1'h0; end
		join
		while (s_axi_bvalid !== 1'h1) @(posedge mclk_i);
		check("bresp", RESP_OKAY, s_axi_bresp);
		s_axi_bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge mclk_i); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge mclk_i);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic quiet(input int n);
		hold_req_i <= 1'h0;
		out_disable_n_i <= 1'h1;
		core_ext_req_i <= 1'h0;
		host_rd_i <= 1'h0;
		hbyte_oe_i <= 1'h0;
		fs_drv <= 1'h0;
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic traffic(input int n);
		logic [31:0] r;
		logic [31:0] v;
		repeat (n) begin
			r = $urandom;
			v = $urandom;
			hold_req_i <= r[2:0] == 3'h0;
			out_disable_n_i <= r[5:3] != 3'h0;
			core_ext_req_i <= r[7:6] == 2'h0;
			core_wr_i <= r[8];
			host_rd_i <= r[9];
			host_port_enable_pin_i <= r[10];
			hbyte_oe_i <= r[11];
			fs_drv <= r[12];
			hbyte_out_i <= r[23:16];
			core_addr_i <= v[15:0];
			core_wdata_i <= v[31:16];
			host_mem_rdata_i <= ~v[15:0];
			fs_val <= v[31:16];
			repeat (1 + int'(r[30:28])) @(posedge mclk_i);
		end
	endtask
	// ---------
	// Main sequence
	// ---------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] v;
		logic        w, p, g;
		void'($urandom(84012));
		for (int c = 0; c < 4; c++) begin
			w = c[0];
			p = c[1];
			g = w || !p;
			quiet(1);
			rst_i <= 1'h1;
			word_host_mode_sel_i <= w;
			host_port_enable_pin_i <= p;
			repeat (8) @(posedge mclk_i);
			rst_i <= 1'h0;
			@(posedge mclk_i);
			check("word_mode", w, word_mode_o);
			check("addr keep reset", 0, addr_hold_en_o);
			check("data keep reset", 0, data_hold_en_o);
			if (!w) check("byte keep reset", 0, byte_hold_en_o);
			traffic(120);
			check("port_en kept", p, port_en_o);
			quiet(6);
			axi_rd(OFF_STATUS, d, r);
			check("status modes", {p, w}, d[1:0]);
			axi_rd(8'h40, d, r);
			check("unmapped resp", RESP_SLVERR, r);
			for (int k = 0; k < 4; k++) begin
				axi_wr(OFF_BANK_SWITCH_CONTROL_REG, k);
				axi_rd(OFF_BANK_SWITCH_CONTROL_REG, d, r);
				check("bank_switch_control_reg", k, d);
				v = 16'($urandom);
				core_ext_req_i <= 1'h1;
				core_wr_i <= 1'h1;
				core_wdata_i <= v;
				@(posedge mclk_i);
				core_ext_req_i <= 1'h0;
				repeat (5) @(posedge mclk_i);
				check("data keep en", {16{k[0]}}, data_hold_en_o);
				check("data keep val", v, data_hold_val_o);
				check("addr keep en", {16{k[1]}}, addr_hold_en_o);
				check("byte keep en", byte_keep_exp(w, k[1]), byte_hold_en_o);
			end
			axi_wr(OFF_GPIO_DIR, 32'hFF);
			axi_wr(OFF_GPIO_OUT, {24'h0, v[7:0]});
			repeat (5) @(posedge mclk_i);
			check("gpio oe", g ? 8'hFF : 8'h00, host_byte_data_pins_oe_o);
			axi_rd(OFF_GPIO_IN, d, r);
			if (g) check("gpio in", v[7:0], d[7:0]);
			if (g) check("byte in pin", v[7:0], hbyte_in_o);
			out_disable_n_i <= 1'h0;
			repeat (6) @(posedge mclk_i);
			check("byte off", 8'h00, host_byte_data_pins_oe_o);
			out_disable_n_i <= 1'h1;
			hbyte_oe_i <= !g;
			hbyte_out_i <= v[15:8];
			axi_wr(OFF_GPIO_DIR, 32'h0);
			repeat (5) @(posedge mclk_i);
			if (!g) check("byte host out", v[15:8], host_byte_data_pins_o);
			check("byte oe", g ? 8'h00 : 8'hFF, host_byte_data_pins_oe_o);
		end
		print_verdict();
	end
endmodule
